/* File: include/facs_adc_if.sv */
// adc channel carrier between the top and its capture stage
`timescale 1ns/1ns
interface facs_adc_if #(parameter int W = facs_pkg::ADC_WIDTH);
  logic strobe_pin;
  logic [W-1:0] data_pin;
  logic [W-1:0] sample;
  logic valid;
  modport cap (input strobe_pin, input data_pin, output sample, output valid);
  modport top (output strobe_pin, output data_pin, input sample, input valid);
endinterface : facs_adc_if

/* File: include/facs_pkg.sv */
// constants, register map and option defaults for the fifo and adc clock selection block
// Summary of operation
// - fifo main clock follows the 100 MHz oscillator, or half of it when halving
// - common-domain option: one clock drives both input and output fifo clocks
// - common domain with fast option: high-range delay lock conditions fifo clocks
// - common domain without fast option: low-range delay lock conditions fifo clocks
// - split domain: each fifo clocked from its own separately sourced clock
// - split domain: input fifo clock uses high or low range per its fast option
// - split domain: output fifo clock uses high or low range per its fast option
// - adc samples are registered on the adc data strobe clock, up to 210 MHz
// - each adc channel drives its own external clock multiplexer select bit
// - shared-source option gives both adcs one source, else chosen per channel
// - shared source: global internal select picks internal or external for both adcs
// - separate sources: channel a internal select picks its internal or external clock
// - separate sources: channel b internal select picks its internal or external clock
// - options not applying to the chosen arrangement have no effect
package facs_pkg;
  // frequencies in MHz, then adc sample width and apb address width in bits
  localparam int OSC_FREQ_MHZ = 100;
  localparam int HALF_FREQ_MHZ = 50;
  localparam int DLL_HIGH_MIN_MHZ = 60;
  localparam int ADC_MAX_MHZ = 210;
  localparam int ADC_WIDTH = 12;
  localparam int APB_AW = 8;
  // register byte offsets
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] SAMPLE_A_OFS = 8'h0c;
  localparam logic [7:0] SAMPLE_B_OFS = 8'h10;
  // config register fields
  localparam int CFG_HALVE = 0;
  localparam int CFG_COMMON = 1;
  localparam int CFG_SHARED_FAST = 2;
  localparam int CFG_INPUT_FAST = 3;
  localparam int CFG_OUTPUT_FAST = 4;
  localparam int CFG_ADC_SHARED = 5;
  localparam int CFG_INT_G = 6;
  localparam int CFG_INT_A = 7;
  localparam int CFG_INT_B = 8;
  localparam int CFG_W = 9;
  // control and status fields
  localparam int CTRL_LOCK = 0;
  localparam int ST_IN_HIGH = 0;
  localparam int ST_OUT_HIGH = 1;
  localparam int ST_MUX_A = 2;
  localparam int ST_MUX_B = 3;
  localparam int ST_LOCKED = 4;
  localparam int ST_MAIN_CLK = 5;
  // option defaults: halving off, common domain, fast shared clock, internal adc clocks
  localparam logic [8:0] CFG_RESET = 9'h1ce;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : facs_pkg

/* File: verif/facs_far_model.sv */
// far side: oscillator, fifo clock sources and two adc channels
`timescale 1ns/1ns
module facs_far_model #(
  parameter int W = facs_pkg::ADC_WIDTH
) (
  output logic osc_pin,
  output logic in_src,
  output logic out_src,
  output logic str_a,
  output logic [W-1:0] dat_a,
  output logic str_b,
  output logic [W-1:0] dat_b
);
  // free-running sources, oscillator slowed so every level is sampled
  initial begin
    osc_pin = 1'b0;
    forever #20 osc_pin = ~osc_pin;
  end
  initial begin
    in_src = 1'b0;
    forever #24 in_src = ~in_src;
  end
  initial begin
    out_src = 1'b0;
    forever #60 out_src = ~out_src;
  end
  // new data launched on strobe fall so it is settled around each rise
  initial begin
    str_a = 1'b0;
    dat_a = {W{1'b0}};
    forever begin
      #64 str_a = ~str_a;
      if (!str_a) dat_a = dat_a + 1'b1;
    end
  end
  initial begin
    str_b = 1'b0;
    dat_b = {W{1'b1}};
    forever begin
      #80 str_b = ~str_b;
      if (!str_b) dat_b = dat_b - 1'b1;
    end
  end
endmodule : facs_far_model

/* File: verif/facs_top_properties.sv */
// concurrent checks on the clock selection top ports
`timescale 1ns/1ns
module facs_top_properties #(
  parameter int W = facs_pkg::ADC_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [facs_pkg::APB_AW-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_high_range_delay_lock,
  input wire logic in_low_range_delay_lock,
  input wire logic out_high_range_delay_lock,
  input wire logic out_low_range_delay_lock,
  input wire logic adc_a_mux_internal,
  input wire logic adc_b_mux_internal,
  input wire logic adc_a_data_strobe_clock,
  input wire logic [W-1:0] adc_a_data,
  input wire logic [W-1:0] adc_a_sample,
  input wire logic adc_a_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer comes within two edges of the access phase and lasts one cycle
  ready_timing_a: assert property (psel && penable && !pready |-> ##[1:2] pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_addr_err_a: assert property (psel && penable && pready &&
    (paddr[1:0] != 2'h0 || paddr > 8'h10) |-> pslverr)
    else $error("bad address not refused");
  // delay lock range selects are always exactly one of the two
  in_lock_pair_a: assert property (in_low_range_delay_lock == !in_high_range_delay_lock)
    else $error("input range selects not complementary");
  out_lock_pair_a: assert property (out_low_range_delay_lock == !out_high_range_delay_lock)
    else $error("output range selects not complementary");
  // multiplexer controls only move two sampled edges after a completed write
  mux_a_static_a: assert property ($changed(adc_a_mux_internal) && $past(presetn) &&
    $past(presetn, 2) |-> $past(pready, 2) && $past(pwrite, 2))
    else $error("mux a changed without write");
  mux_b_static_a: assert property ($changed(adc_b_mux_internal) && $past(presetn) &&
    $past(presetn, 2) |-> $past(pready, 2) && $past(pwrite, 2))
    else $error("mux b changed without write");
  // each channel a strobe rise yields one capture of the data beside it
  strobe_valid_a: assert property ($rose(adc_a_data_strobe_clock) |-> ##[3:6] adc_a_valid)
    else $error("strobe not captured");
  sample_match_a: assert property (adc_a_valid |-> adc_a_sample == $past(adc_a_data, 4))
    else $error("captured sample wrong");
endmodule : facs_top_properties
bind facs_top facs_top_properties #(.W(W)) i_facs_top_properties (.*);

/* File: verif/facs_top_tb_top.sv */
// self-checking bench for the clock selection top
`timescale 1ns/1ns
module facs_top_tb_top;
  typedef struct packed {logic [8:0] cfg; logic [3:0] sel;} facs_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, clr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic osc_pin, in_src, out_src, str_a, str_b, main_clk, fifo_in_clk, fifo_out_clk;
  logic ih, il, oh, ol, mux_a, mux_b, val_a, val_b;
  logic [facs_pkg::ADC_WIDTH-1:0] dat_a, dat_b, smp_a, smp_b;
  logic [9:0] sig, prv;
  int cnt [10];
  int fails, comparisons;
  // config rows beside the expected {mux_b, mux_a, out_high, in_high}
  facs_row_t rows [9] = '{'{9'h006, 4'h3}, '{9'h01a, 4'h0}, '{9'h00c, 4'h1},
    '{9'h010, 4'h2}, '{9'h060, 4'hc}, '{9'h1a0, 4'h0}, '{9'h0c0, 4'h4},
    '{9'h100, 4'h8}, '{9'h003, 4'h0}};
  facs_top i_facs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .osc_pin(osc_pin), .input_fifo_clock_source(in_src),
    .output_fifo_clock_source(out_src), .adc_a_data_strobe_clock(str_a), .adc_a_data(dat_a),
    .adc_b_data_strobe_clock(str_b), .adc_b_data(dat_b), .main_clk(main_clk),
    .fifo_in_clk(fifo_in_clk), .fifo_out_clk(fifo_out_clk), .in_high_range_delay_lock(ih),
    .in_low_range_delay_lock(il), .out_high_range_delay_lock(oh),
    .out_low_range_delay_lock(ol), .adc_a_mux_internal(mux_a), .adc_b_mux_internal(mux_b),
    .adc_a_sample(smp_a), .adc_a_valid(val_a), .adc_b_sample(smp_b), .adc_b_valid(val_b));
  facs_far_model i_facs_far_model (.osc_pin(osc_pin), .in_src(in_src), .out_src(out_src),
    .str_a(str_a), .dat_a(dat_a), .str_b(str_b), .dat_b(dat_b));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // rising-edge counters over a measuring window
  assign sig = {val_b, str_b, val_a, str_a, fifo_out_clk, fifo_in_clk, out_src, in_src,
    main_clk, osc_pin};
  always @(posedge pclk) begin
    prv <= sig;
    for (int i = 0; i < 10; i++) cnt[i] <= clr ? 0 : cnt[i] + int'(sig[i] && !prv[i]);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      fails++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic win();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (400) @(posedge pclk);
  endtask : win
  function automatic logic near(input int a, input int b);
    return (a > b ? a - b : b - a) <= 2;
  endfunction : near
  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, presetn, clr} = 5'h01;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    chk("sel_in_reset", {mux_b, mux_a, ol, il, pready}, 5'h06);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, facs_pkg::CONFIG_OFS, 32'h0);
    chk("cfg_reset", rd, 32'h0000_01ce);
    apb(1'b0, facs_pkg::STATUS_OFS, 32'h0);
    chk("status_reset", rd[4:0], 5'h0f);
    foreach (rows[i]) begin
      apb(1'b1, facs_pkg::CONFIG_OFS, {23'h0, rows[i].cfg});
      repeat (2) @(posedge pclk);
      chk("sel", {mux_b, mux_a, oh, ih}, rows[i].sel);
      chk("low_range", {ol, il}, rows[i].sel[1:0] ^ 2'h3);
      apb(1'b0, facs_pkg::STATUS_OFS, 32'h0);
      chk("status", rd[3:0], rows[i].sel);
      apb(1'b0, facs_pkg::CONFIG_OFS, 32'h0);
      chk("cfg", rd, {23'h0, rows[i].cfg});
      win();
      chk("main_rate", near(cnt[1] * (rows[i].cfg[0] ? 2 : 1), cnt[0]), 1'b1);
      chk("in_clk", near(cnt[4], cnt[rows[i].cfg[1] ? 1 : 2]), 1'b1);
      chk("out_clk", near(cnt[5], cnt[rows[i].cfg[1] ? 1 : 3]), 1'b1);
      chk("captures", near(cnt[7] + cnt[9], cnt[6] + cnt[8]), 1'b1);
    end
    // captured samples match the data standing beside one strobe rise of each channel
    @(posedge str_a);
    repeat (8) @(posedge pclk);
    chk("sample_a", smp_a, dat_a);
    apb(1'b0, facs_pkg::SAMPLE_A_OFS, 32'h0);
    chk("sample_a_reg", rd, {20'h0, dat_a});
    @(posedge str_b);
    repeat (8) @(posedge pclk);
    chk("sample_b", smp_b, dat_b);
    apb(1'b0, facs_pkg::SAMPLE_B_OFS, 32'h0);
    chk("sample_b_reg", rd, {20'h0, dat_b});
    // refused and read-only places
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 32'h0000_0000);
    apb(1'b0, 8'h02, 32'h0);
    chk("misaligned", er, 1'b1);
    apb(1'b1, facs_pkg::STATUS_OFS, 32'hffff_ffff);
    chk("status_write", er, 1'b0);
    // after lock the selection stays put
    apb(1'b1, facs_pkg::CTRL_OFS, 32'h1);
    apb(1'b1, facs_pkg::CONFIG_OFS, 32'h0c0);
    chk("locked_write", er, 1'b1);
    repeat (3) @(posedge pclk);
    chk("locked_mux", {mux_b, mux_a}, 2'h0);
    apb(1'b0, facs_pkg::CONFIG_OFS, 32'h0);
    chk("locked_cfg", rd, 32'h0000_0003);
    apb(1'b0, facs_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_lock", rd, 32'h0000_0001);
    apb(1'b0, facs_pkg::STATUS_OFS, 32'h0);
    chk("status_lock", rd[4:0], 5'h10);
    // second reset clears the lock
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("sel_mid_reset", {mux_b, mux_a, ol, il}, 4'h3);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, facs_pkg::CONFIG_OFS, 32'h0);
    chk("cfg_rereset", rd, 32'h0000_01ce);
    apb(1'b1, facs_pkg::CONFIG_OFS, 32'h0c0);
    chk("unlocked_write", er, 1'b0);
    end_of_test();
  end
endmodule : facs_top_tb_top

/* File: verilog/facs_adc_capture.sv */
// registers one adc channel's samples on its data strobe clock
`timescale 1ns/1ns
module facs_adc_capture #(
  parameter int W = facs_pkg::ADC_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  facs_adc_if.cap adc
);
  logic s1_r, s2_r, s3_r;
  logic [W-1:0] d1_r, d2_r, d3_r;
  logic lvl_r, lvl_nxt;
  logic [W-1:0] sample_r, sample_nxt;
  logic valid_r, valid_nxt;
  logic edge_seen;

  // data travels beside the strobe so both reach stage three together
  always_comb begin
    edge_seen = (s2_r == s3_r) && s3_r && !lvl_r;
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
    sample_nxt = edge_seen ? d3_r : sample_r;
    valid_nxt = edge_seen;
  end

  // synchroniser stages and captured sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      d1_r <= '0;
      d2_r <= '0;
      d3_r <= '0;
      lvl_r <= 1'b0;
      sample_r <= '0;
      valid_r <= 1'b0;
    end else begin
      s1_r <= adc.strobe_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      d1_r <= adc.data_pin;
      d2_r <= d1_r;
      d3_r <= d2_r;
      lvl_r <= lvl_nxt;
      sample_r <= sample_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign adc.sample = sample_r;
  assign adc.valid = valid_r;
endmodule : facs_adc_capture

/* File: verilog/facs_clk_div.sv */
// oscillator synchroniser and optional divide-by-two for the fifo main clock
`timescale 1ns/1ns
module facs_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_pin,
  input wire logic halve,
  output logic main_clk
);
  logic s1_r, s2_r, s3_r;
  logic lvl_r, lvl_nxt;
  logic half_r, half_nxt;
  logic main_r, main_nxt;
  logic agree;

  // accepted oscillator level moves only when the last two stages agree
  always_comb begin
    agree = (s2_r == s3_r);
    lvl_nxt = agree ? s3_r : lvl_r;
    half_nxt = half_r;
    if (agree && s3_r && !lvl_r) begin
      half_nxt = !half_r; // toggles once per oscillator period
    end
    main_nxt = halve ? half_r : lvl_r;
  end

  // three-stage synchroniser and divider state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
      half_r <= 1'b0;
      main_r <= 1'b0;
    end else begin
      s1_r <= osc_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      half_r <= half_nxt;
      main_r <= main_nxt;
    end
  end

  assign main_clk = main_r;
endmodule : facs_clk_div

/* File: verilog/facs_top.sv */
// fifo and adc clock selection top with apb configuration and status registers
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module facs_top #(
  parameter logic [8:0] CFG_DEFAULT = facs_pkg::CFG_RESET,
  parameter int W = facs_pkg::ADC_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [facs_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic osc_pin,
  input wire logic input_fifo_clock_source,
  input wire logic output_fifo_clock_source,
  input wire logic adc_a_data_strobe_clock,
  input wire logic [W-1:0] adc_a_data,
  input wire logic adc_b_data_strobe_clock,
  input wire logic [W-1:0] adc_b_data,
  output logic main_clk,
  output logic fifo_in_clk,
  output logic fifo_out_clk,
  output logic in_high_range_delay_lock,
  output logic in_low_range_delay_lock,
  output logic out_high_range_delay_lock,
  output logic out_low_range_delay_lock,
  output logic adc_a_mux_internal,
  output logic adc_b_mux_internal,
  output logic [W-1:0] adc_a_sample,
  output logic adc_a_valid,
  output logic [W-1:0] adc_b_sample,
  output logic adc_b_valid
);

  // shared-or-own selection used for both delay locks and both adc muxes
  function automatic logic pick(input logic shared, input logic shared_val,
                                input logic own_val);
    pick = shared ? shared_val : own_val;
  endfunction : pick

  // configuration and lock state
  logic [facs_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
  logic lock_r, lock_nxt;

  // apb answer state
  logic pready_r, pready_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;

  // clock selection outputs
  logic fifo_in_r, fifo_in_nxt;
  logic fifo_out_r, fifo_out_nxt;
  logic in_high_r, in_high_nxt;
  logic out_high_r, out_high_nxt;
  logic in_low_r, in_low_nxt;
  logic out_low_r, out_low_nxt;
  logic mux_a_r, mux_a_nxt;
  logic mux_b_r, mux_b_nxt;

  // synchronisers for the split-domain clock sources
  logic [2:0] in_sync_r, out_sync_r;
  logic in_lvl_r, in_lvl_nxt;
  logic out_lvl_r, out_lvl_nxt;

  // internal decode signals
  logic main_lvl;
  logic setup_ph, complete;
  logic [facs_pkg::APB_AW-1:0] word_addr;
  logic mapped, misaligned, wr_refused;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic in_fast_sel, out_fast_sel;

  // adc channel carriers
  facs_adc_if #(.W(W)) adc_a_if ();
  facs_adc_if #(.W(W)) adc_b_if ();

  assign adc_a_if.strobe_pin = adc_a_data_strobe_clock;
  assign adc_a_if.data_pin = adc_a_data;
  assign adc_b_if.strobe_pin = adc_b_data_strobe_clock;
  assign adc_b_if.data_pin = adc_b_data;

  // oscillator path, divided or direct
  facs_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .osc_pin(osc_pin),
    .halve(cfg_r[facs_pkg::CFG_HALVE]),
    .main_clk(main_lvl)
  );

  // one capture stage per adc channel
  facs_adc_capture #(.W(W)) u_cap_a (
    .pclk(pclk),
    .presetn(presetn),
    .adc(adc_a_if.cap)
  );

  facs_adc_capture #(.W(W)) u_cap_b (
    .pclk(pclk),
    .presetn(presetn),
    .adc(adc_b_if.cap)
  );

  // apb phase decode
  always_comb begin
    setup_ph = psel && penable && !pready_r;
    complete = psel && penable && pready_r;
    word_addr = {paddr[facs_pkg::APB_AW-1:2], 2'b00};
    misaligned = (paddr[1:0] != 2'b00);
    mapped = !misaligned && ((word_addr == facs_pkg::CONFIG_OFS) ||
                             (word_addr == facs_pkg::CTRL_OFS) ||
                             (word_addr == facs_pkg::STATUS_OFS) ||
                             (word_addr == facs_pkg::SAMPLE_A_OFS) ||
                             (word_addr == facs_pkg::SAMPLE_B_OFS));
    // a locked configuration refuses further writes
    wr_refused = pwrite && lock_r && (word_addr == facs_pkg::CONFIG_OFS);
  end

  // status word shows what the block actually drives
  always_comb begin
    status_word = facs_pkg::ZERO_WORD;
    status_word[facs_pkg::ST_IN_HIGH] = in_high_r;
    status_word[facs_pkg::ST_OUT_HIGH] = out_high_r;
    status_word[facs_pkg::ST_MUX_A] = mux_a_r;
    status_word[facs_pkg::ST_MUX_B] = mux_b_r;
    status_word[facs_pkg::ST_LOCKED] = lock_r;
    status_word[facs_pkg::ST_MAIN_CLK] = main_lvl;
  end

  // read data mux
  always_comb begin
    rd_word = facs_pkg::ZERO_WORD;
    case (word_addr)
      facs_pkg::CONFIG_OFS: begin
        rd_word[facs_pkg::CFG_W-1:0] = cfg_r;
      end
      facs_pkg::CTRL_OFS: begin
        rd_word[facs_pkg::CTRL_LOCK] = lock_r;
      end
      facs_pkg::STATUS_OFS: begin
        rd_word = status_word;
      end
      facs_pkg::SAMPLE_A_OFS: begin
        rd_word[W-1:0] = adc_a_if.sample;
      end
      facs_pkg::SAMPLE_B_OFS: begin
        rd_word[W-1:0] = adc_b_if.sample;
      end
      default: begin
        rd_word = facs_pkg::ZERO_WORD;
      end
    endcase
  end

  // apb answer: one wait state, data and error prepared before pready rises
  always_comb begin
    pready_nxt = setup_ph;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (setup_ph) begin
      prdata_nxt = (pwrite || !mapped) ? facs_pkg::ZERO_WORD : rd_word;
      pslverr_nxt = !mapped || wr_refused;
    end
  end

  // configuration writes take effect only at the completing edge
  always_comb begin
    cfg_nxt = cfg_r;
    lock_nxt = lock_r;
    if (complete && pwrite && mapped) begin
      if ((word_addr == facs_pkg::CONFIG_OFS) && !lock_r) begin
        cfg_nxt = pwdata[facs_pkg::CFG_W-1:0];
      end
      if ((word_addr == facs_pkg::CTRL_OFS) && pwdata[facs_pkg::CTRL_LOCK]) begin
        lock_nxt = 1'b1;
      end
    end
  end

  // split-domain source levels, accepted when stages two and three agree
  always_comb begin
    in_lvl_nxt = (in_sync_r[1] == in_sync_r[2]) ? in_sync_r[2] : in_lvl_r;
    out_lvl_nxt = (out_sync_r[1] == out_sync_r[2]) ? out_sync_r[2] : out_lvl_r;
  end

  // fifo clock routing
  always_comb begin
    if (cfg_r[facs_pkg::CFG_COMMON]) begin
      fifo_in_nxt = main_lvl;
      fifo_out_nxt = main_lvl;
    end else begin
      fifo_in_nxt = in_lvl_r;
      fifo_out_nxt = out_lvl_r;
    end
  end

  // delay lock range choice; the unused option is ignored
  always_comb begin
    in_fast_sel = pick(cfg_r[facs_pkg::CFG_COMMON], cfg_r[facs_pkg::CFG_SHARED_FAST],
                       cfg_r[facs_pkg::CFG_INPUT_FAST]);
    out_fast_sel = pick(cfg_r[facs_pkg::CFG_COMMON], cfg_r[facs_pkg::CFG_SHARED_FAST],
                        cfg_r[facs_pkg::CFG_OUTPUT_FAST]);
    in_high_nxt = in_fast_sel;
    out_high_nxt = out_fast_sel;
    in_low_nxt = !in_fast_sel;
    out_low_nxt = !out_fast_sel;
  end

  // adc sample clock multiplexer selects, high means internal clock
  always_comb begin
    mux_a_nxt = pick(cfg_r[facs_pkg::CFG_ADC_SHARED], cfg_r[facs_pkg::CFG_INT_G],
                     cfg_r[facs_pkg::CFG_INT_A]);
    mux_b_nxt = pick(cfg_r[facs_pkg::CFG_ADC_SHARED], cfg_r[facs_pkg::CFG_INT_G],
                     cfg_r[facs_pkg::CFG_INT_B]);
  end

  // configuration and lock registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_DEFAULT;
      lock_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      lock_r <= lock_nxt;
    end
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= facs_pkg::ZERO_WORD;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // split-source synchronisers; stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sync_r <= 3'h0;
      out_sync_r <= 3'h0;
      in_lvl_r <= 1'b0;
      out_lvl_r <= 1'b0;
    end else begin
      in_sync_r <= {in_sync_r[1:0], input_fifo_clock_source};
      out_sync_r <= {out_sync_r[1:0], output_fifo_clock_source};
      in_lvl_r <= in_lvl_nxt;
      out_lvl_r <= out_lvl_nxt;
    end
  end

  // clock selection output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_in_r <= 1'b0;
      fifo_out_r <= 1'b0;
      in_high_r <= 1'b0;
      out_high_r <= 1'b0;
      in_low_r <= 1'b1; // low range selected while in reset
      out_low_r <= 1'b1;
      mux_a_r <= 1'b0;
      mux_b_r <= 1'b0;
    end else begin
      fifo_in_r <= fifo_in_nxt;
      fifo_out_r <= fifo_out_nxt;
      in_high_r <= in_high_nxt;
      out_high_r <= out_high_nxt;
      in_low_r <= in_low_nxt;
      out_low_r <= out_low_nxt;
      mux_a_r <= mux_a_nxt;
      mux_b_r <= mux_b_nxt;
    end
  end

  // outputs
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign main_clk = main_lvl;
  assign fifo_in_clk = fifo_in_r;
  assign fifo_out_clk = fifo_out_r;
  assign in_high_range_delay_lock = in_high_r;
  assign in_low_range_delay_lock = in_low_r;
  assign out_high_range_delay_lock = out_high_r;
  assign out_low_range_delay_lock = out_low_r;
  assign adc_a_mux_internal = mux_a_r;
  assign adc_b_mux_internal = mux_b_r;
  assign adc_a_sample = adc_a_if.sample;
  assign adc_a_valid = adc_a_if.valid;
  assign adc_b_sample = adc_b_if.sample;
  assign adc_b_valid = adc_b_if.valid;

endmodule : facs_top
